// ---- ipr_pkg.sv ----
// Purpose: Shared constants and types for the interrupt priority register block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are chosen locally; fields are 3 bits in four slots per register
package ipr_pkg;
    localparam int unsigned NUM_REGS = 4;
    localparam int unsigned NUM_SRC = 15;
    localparam int unsigned PRIO_W = 3;
    localparam logic [11:0] OFS_CC_A = 12'h000;
    localparam logic [11:0] OFS_TDC = 12'h004;
    localparam logic [11:0] OFS_TI2C = 12'h008;
    localparam logic [11:0] OFS_CET = 12'h00c;
    // Field low-bit positions inside a 16-bit register
    localparam int unsigned POS_F3 = 12;
    localparam int unsigned POS_F2 = 8;
    localparam int unsigned POS_F1 = 4;
    localparam int unsigned POS_F0 = 0;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    // Writable masks per register
    localparam logic [15:0] MASK_FULL = 16'h7777;
    localparam logic [15:0] MASK_TDC = 16'h7707;
    localparam logic [15:0] RST_FULL = 16'h4444;
    localparam logic [15:0] RST_TDC = 16'h4404;

    typedef struct packed {
        logic [15:0] cc_a_reg;
        logic [15:0] tdc_reg;
        logic [15:0] ti2c_reg;
        logic [15:0] cet_reg;
        logic [31:0] prdata_reg;
        logic pslverr_reg;
    } ipr_state_t;

    typedef struct packed {
        logic [2:0] compare7_priority;
        logic [2:0] compare6_priority;
        logic [2:0] compare5_priority;
        logic [2:0] capture6_priority;
        logic [2:0] timer6_priority;
        logic [2:0] dma_ch4_done_priority;
        logic [2:0] compare8_priority;
        logic [2:0] timer8_priority;
        logic [2:0] i2c_b_master_priority;
        logic [2:0] i2c_b_slave_priority;
        logic [2:0] timer7_priority;
        logic [2:0] can_b_rx_ready_priority;
        logic [2:0] ext_irq4_priority;
        logic [2:0] ext_irq3_priority;
        logic [2:0] timer9_priority;
    } ipr_prio_t;
endpackage

// ---- ipr_regs.sv ----
// Purpose: Four interrupt priority registers on APB, with per-source level and gated request outputs
// Assumes: Single 10 MHz clock, synchronous active-low reset, APB master per protocol
// Notes: Zero wait states; unmapped address answers with pslverr and reads zero
// Notes: Offsets 0x000 to 0x00c, each 16-bit register in the low half of its word
// Notes: Requests of sources at code zero are masked before they leave the block
// Notes on behaviour
// R1: Each priority field is three bits; code 7 is the highest peripheral level.
// R2: Code 1 is lowest enabled level; codes 2 to 6 map linearly.
// R3: Code 0 disables the source so it never requests an interrupt.
// R4: Unimplemented bits, including bits 7-3 of second register, read zero.
// R5: Reset loads each field with 100, level four; all fields read-write.
// R6: First register: compare7, compare6, compare5, capture6 from high to low.
// R7: Second register: timer6, dma channel 4 done, compare8; bits 7-3 absent.
// R8: Third register: timer8, i2c b master, i2c b slave, timer7.
// R9: Fourth register: can b receive ready, ext irq4, ext irq3, timer9.
// R10: Writes apply for the next arbitration; writes to absent bits ignored.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
module ipr_regs (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [ipr_pkg::NUM_SRC-1:0] src_req_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output ipr_pkg::ipr_prio_t prio_out,
    output logic [ipr_pkg::NUM_SRC*3-1:0] level_out,
    output logic [ipr_pkg::NUM_SRC-1:0] req_active_out
);
    ipr_pkg::ipr_state_t st_reg;
    ipr_pkg::ipr_state_t st_next;
    logic access;
    logic [15:0] wmask;
    logic [15:0] rdval;
    logic hit;
    logic [15:0] lane_mask;
    logic [ipr_pkg::NUM_SRC*3-1:0] flat;

    // Access phase of an APB transfer; no wait states are ever inserted
    assign access = psel_in && penable_in;
    assign pready_out = 1'b1;
    assign prdata_out = st_reg.prdata_reg;
    assign pslverr_out = st_reg.pslverr_reg & access;
    // Only the two low byte lanes carry register bits
    assign lane_mask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

    // Address decode with read value and writable mask per register
    always_comb begin
        hit = 1'b1;
        wmask = ipr_pkg::MASK_FULL;
        rdval = 16'h0000;
        unique case (paddr_in)
            ipr_pkg::OFS_CC_A: rdval = st_reg.cc_a_reg; // [R6]
            ipr_pkg::OFS_TDC: begin
                rdval = st_reg.tdc_reg; // [R7]
                wmask = ipr_pkg::MASK_TDC; // [R4]
            end
            ipr_pkg::OFS_TI2C: rdval = st_reg.ti2c_reg; // [R8]
            ipr_pkg::OFS_CET: rdval = st_reg.cet_reg; // [R9]
            default: begin
                hit = 1'b0;
                wmask = 16'h0000;
            end
        endcase
    end

    // Next state: writes merge under mask so absent bits stay zero
    always_comb begin
        st_next = st_reg;
        st_next.pslverr_reg = psel_in && !penable_in && !hit;
        if (psel_in && !penable_in && !pwrite_in) begin
            st_next.prdata_reg = {16'h0000, rdval & wmask}; // [R4]
        end
        if (access && pwrite_in && hit) begin
            unique case (paddr_in)
                ipr_pkg::OFS_CC_A: st_next.cc_a_reg = pwdata_in[15:0] & wmask & lane_mask; // [R10]
                ipr_pkg::OFS_TDC: st_next.tdc_reg = (st_reg.tdc_reg & ~(wmask & lane_mask))
                    | (pwdata_in[15:0] & wmask & lane_mask); // [R10]
                ipr_pkg::OFS_TI2C: st_next.ti2c_reg = pwdata_in[15:0] & wmask & lane_mask;
                default: st_next.cet_reg = pwdata_in[15:0] & wmask & lane_mask;
            endcase
            if (paddr_in == ipr_pkg::OFS_CC_A) st_next.cc_a_reg |= st_reg.cc_a_reg & ~lane_mask;
            if (paddr_in == ipr_pkg::OFS_TI2C) st_next.ti2c_reg |= st_reg.ti2c_reg & ~lane_mask;
            if (paddr_in == ipr_pkg::OFS_CET) st_next.cet_reg |= st_reg.cet_reg & ~lane_mask;
        end
        if (!rstn_in) begin
            st_next = '0;
            st_next.cc_a_reg = ipr_pkg::RST_FULL; // [R5]
            st_next.tdc_reg = ipr_pkg::RST_TDC; // [R5]
            st_next.ti2c_reg = ipr_pkg::RST_FULL;
            st_next.cet_reg = ipr_pkg::RST_FULL;
        end
    end

    // Single state register, synchronous reset folded into the next value
    always_ff @(posedge sys_clk_in) begin
        st_reg <= st_next;
    end

    // Field extraction in source order
    always_comb begin
        prio_out.compare7_priority = st_reg.cc_a_reg[ipr_pkg::POS_F3 +: 3]; // [R6]
        prio_out.compare6_priority = st_reg.cc_a_reg[ipr_pkg::POS_F2 +: 3];
        prio_out.compare5_priority = st_reg.cc_a_reg[ipr_pkg::POS_F1 +: 3];
        prio_out.capture6_priority = st_reg.cc_a_reg[ipr_pkg::POS_F0 +: 3];
        prio_out.timer6_priority = st_reg.tdc_reg[ipr_pkg::POS_F3 +: 3]; // [R7]
        prio_out.dma_ch4_done_priority = st_reg.tdc_reg[ipr_pkg::POS_F2 +: 3];
        prio_out.compare8_priority = st_reg.tdc_reg[ipr_pkg::POS_F0 +: 3];
        prio_out.timer8_priority = st_reg.ti2c_reg[ipr_pkg::POS_F3 +: 3]; // [R8]
        prio_out.i2c_b_master_priority = st_reg.ti2c_reg[ipr_pkg::POS_F2 +: 3];
        prio_out.i2c_b_slave_priority = st_reg.ti2c_reg[ipr_pkg::POS_F1 +: 3];
        prio_out.timer7_priority = st_reg.ti2c_reg[ipr_pkg::POS_F0 +: 3];
        prio_out.can_b_rx_ready_priority = st_reg.cet_reg[ipr_pkg::POS_F3 +: 3]; // [R9]
        prio_out.ext_irq4_priority = st_reg.cet_reg[ipr_pkg::POS_F2 +: 3];
        prio_out.ext_irq3_priority = st_reg.cet_reg[ipr_pkg::POS_F1 +: 3];
        prio_out.timer9_priority = st_reg.cet_reg[ipr_pkg::POS_F0 +: 3];
    end

    // Level is the field value itself: 1..7 linear, 0 means disabled
    assign flat = prio_out;
    assign level_out = flat; // [R1] [R2]

    // Per-source gating: a source at code zero never requests
    genvar gi;
    generate
        for (gi = 0; gi < ipr_pkg::NUM_SRC; gi++) begin : g_src
            assign req_active_out[gi] = src_req_in[gi] && (flat[gi*3 +: 3] != ipr_pkg::PRIO_OFF); // [R3]
            // Per source: code zero keeps it quiet, any other code lets its request through
            gate_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R3]
                (flat[gi*3 +: 3] == ipr_pkg::PRIO_OFF) |-> !req_active_out[gi])
                else $error("quiet source requested");
            gate_pass_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R3]
                (src_req_in[gi] && flat[gi*3 +: 3] != ipr_pkg::PRIO_OFF) |-> req_active_out[gi])
                else $error("enabled source blocked");
        end
    endgenerate

    // A disabled timer9 source never presents a request
    disabled_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R3]
        (prio_out.timer9_priority == 3'h0) |-> !req_active_out[0])
        else $error("disabled source requested");
    // Absent bits of second register stay zero
    absent_bits_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R4]
        st_reg.tdc_reg[7:3] == 5'h00 && st_reg.cc_a_reg[15] == 1'b0)
        else $error("unimplemented bit set");
    // Reset loads level four
    reset_level_a: assert property (@(posedge sys_clk_in) // [R5]
        !rstn_in |=> prio_out.compare7_priority == 3'h4 && prio_out.compare8_priority == 3'h4)
        else $error("reset level wrong");
    // A full write is visible next cycle
    write_apply_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R10]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_CC_A && pstrb_in[1])
        |=> prio_out.compare7_priority == $past(pwdata_in[14:12]))
        else $error("write not applied");
    // Second register keeps its high field mapping
    map_tdc_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R7]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_TDC && pstrb_in[1])
        |=> prio_out.timer6_priority == $past(pwdata_in[14:12]))
        else $error("timer6 field wrong");
    // Third register low field mapping
    map_ti2c_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R8]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_TI2C && pstrb_in[0])
        |=> prio_out.timer7_priority == $past(pwdata_in[2:0]))
        else $error("timer7 field wrong");
    // Fourth register high field mapping
    map_cet_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R9]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_CET && pstrb_in[1])
        |=> prio_out.can_b_rx_ready_priority == $past(pwdata_in[14:12]))
        else $error("can field wrong");
    // Level output equals field code, top code is seven
    level_code_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R1] [R2]
        level_out[2:0] == st_reg.cet_reg[2:0] && level_out[44:42] == st_reg.cc_a_reg[14:12])
        else $error("level mapping wrong");
    // First register low field mapping
    map_cc_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R6]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_CC_A && pstrb_in[0])
        |=> prio_out.capture6_priority == $past(pwdata_in[2:0]))
        else $error("capture6 field wrong");
    // First register, second field from the top
    map_cmp6_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R6]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_CC_A && pstrb_in[1])
        |=> prio_out.compare6_priority == $past(pwdata_in[10:8]))
        else $error("compare6 field wrong");
    // First register, third field from the top
    map_cmp5_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R6]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_CC_A && pstrb_in[0])
        |=> prio_out.compare5_priority == $past(pwdata_in[6:4]))
        else $error("compare5 field wrong");
    // Second register, middle field
    map_dma4_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R7]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_TDC && pstrb_in[1])
        |=> prio_out.dma_ch4_done_priority == $past(pwdata_in[10:8]))
        else $error("dma field wrong");
    // Second register, low field below the absent bits
    map_cmp8_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R7]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_TDC && pstrb_in[0])
        |=> prio_out.compare8_priority == $past(pwdata_in[2:0]))
        else $error("compare8 field wrong");
    // Third register, top field
    map_tmr8_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R8]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_TI2C && pstrb_in[1])
        |=> prio_out.timer8_priority == $past(pwdata_in[14:12]))
        else $error("timer8 field wrong");
    // Third register, master event field
    map_i2cm_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R8]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_TI2C && pstrb_in[1])
        |=> prio_out.i2c_b_master_priority == $past(pwdata_in[10:8]))
        else $error("i2c master field wrong");
    // Third register, slave event field
    map_i2cs_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R8]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_TI2C && pstrb_in[0])
        |=> prio_out.i2c_b_slave_priority == $past(pwdata_in[6:4]))
        else $error("i2c slave field wrong");
    // Fourth register, second field from the top
    map_ext4_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R9]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_CET && pstrb_in[1])
        |=> prio_out.ext_irq4_priority == $past(pwdata_in[10:8]))
        else $error("ext irq4 field wrong");
    // Fourth register, third field from the top
    map_ext3_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R9]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_CET && pstrb_in[0])
        |=> prio_out.ext_irq3_priority == $past(pwdata_in[6:4]))
        else $error("ext irq3 field wrong");
    // Fourth register, low field
    map_tmr9_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R9]
        (access && pwrite_in && paddr_in == ipr_pkg::OFS_CET && pstrb_in[0])
        |=> prio_out.timer9_priority == $past(pwdata_in[2:0]))
        else $error("timer9 field wrong");
    // A lane left out of the strobes keeps its byte, so a narrow write cannot clobber a neighbour
    lane_high_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R10]
        (access && pwrite_in && !pstrb_in[1])
        |=> {st_reg.cc_a_reg[15:8], st_reg.tdc_reg[15:8], st_reg.ti2c_reg[15:8], st_reg.cet_reg[15:8]}
            == $past({st_reg.cc_a_reg[15:8], st_reg.tdc_reg[15:8], st_reg.ti2c_reg[15:8], st_reg.cet_reg[15:8]}))
        else $error("high byte changed without strobe");
    // Same for the low byte lane
    lane_low_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R10]
        (access && pwrite_in && !pstrb_in[0])
        |=> {st_reg.cc_a_reg[7:0], st_reg.tdc_reg[7:0], st_reg.ti2c_reg[7:0], st_reg.cet_reg[7:0]}
            == $past({st_reg.cc_a_reg[7:0], st_reg.tdc_reg[7:0], st_reg.ti2c_reg[7:0], st_reg.cet_reg[7:0]}))
        else $error("low byte changed without strobe");
    // A write to an unmapped word must leave every register alone
    unmapped_write_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R10]
        (access && pwrite_in && !hit)
        |=> {st_reg.cc_a_reg, st_reg.tdc_reg, st_reg.ti2c_reg, st_reg.cet_reg}
            == $past({st_reg.cc_a_reg, st_reg.tdc_reg, st_reg.ti2c_reg, st_reg.cet_reg}))
        else $error("unmapped write changed a register");
    // Setup cycles and reads never move a field; only the access phase of a write does
    idle_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R10]
        !(access && pwrite_in)
        |=> {st_reg.cc_a_reg, st_reg.tdc_reg, st_reg.ti2c_reg, st_reg.cet_reg}
            == $past({st_reg.cc_a_reg, st_reg.tdc_reg, st_reg.ti2c_reg, st_reg.cet_reg}))
        else $error("field moved without write");
    // Error response rises only in the access phase of an unmapped transfer
    unmapped_error_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R10]
        (psel_in && !penable_in && !hit) ##1 access |-> pslverr_out)
        else $error("missing error response");
    mapped_okay_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R10]
        (psel_in && !penable_in && hit) ##1 access |-> !pslverr_out)
        else $error("spurious error response");
    // The upper half of the read word carries no register bits
    upper_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R4]
        prdata_out[31:16] == 16'h0000)
        else $error("upper read half not zero");
    // Read data is the register as it stood in the setup cycle
    read_first_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R6]
        (psel_in && !penable_in && !pwrite_in && paddr_in == ipr_pkg::OFS_CC_A)
        |=> prdata_out[15:0] == $past(st_reg.cc_a_reg))
        else $error("first register read wrong");
    // Second register read back, absent bits included
    read_second_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R7]
        (psel_in && !penable_in && !pwrite_in && paddr_in == ipr_pkg::OFS_TDC)
        |=> prdata_out[15:0] == $past(st_reg.tdc_reg))
        else $error("second register read wrong");
    // Third register read back
    read_third_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R8]
        (psel_in && !penable_in && !pwrite_in && paddr_in == ipr_pkg::OFS_TI2C)
        |=> prdata_out[15:0] == $past(st_reg.ti2c_reg))
        else $error("third register read wrong");
    // Fourth register read back
    read_fourth_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R9]
        (psel_in && !penable_in && !pwrite_in && paddr_in == ipr_pkg::OFS_CET)
        |=> prdata_out[15:0] == $past(st_reg.cet_reg))
        else $error("fourth register read wrong");
    // Every register and the bus outputs come out of reset at known values
    reset_regs_a: assert property (@(posedge sys_clk_in) // [R5]
        !rstn_in |=> st_reg.cc_a_reg == ipr_pkg::RST_FULL && st_reg.tdc_reg == ipr_pkg::RST_TDC
            && st_reg.ti2c_reg == ipr_pkg::RST_FULL && st_reg.cet_reg == ipr_pkg::RST_FULL
            && prdata_out == 32'h00000000 && !pslverr_out)
        else $error("register reset value wrong");
    // The slave never stretches a transfer
    zero_wait_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R10]
        access |-> pready_out)
        else $error("wait state inserted");
    // Read data stands until the next read setup, so a slow master still sees it
    prdata_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R4]
        !(psel_in && !penable_in && !pwrite_in) |=> prdata_out == $past(prdata_out))
        else $error("read data moved");
    // Gap bits between fields of every register stay zero
    spare_bits_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // [R4]
        (st_reg.cc_a_reg & ~ipr_pkg::MASK_FULL) == 16'h0000 && (st_reg.tdc_reg & ~ipr_pkg::MASK_TDC) == 16'h0000
            && (st_reg.ti2c_reg & ~ipr_pkg::MASK_FULL) == 16'h0000 && (st_reg.cet_reg & ~ipr_pkg::MASK_FULL) == 16'h0000)
        else $error("gap bit set");
endmodule // ipr_regs

// ---- ipr_regs_tb.sv ----
// Purpose: Self-checking bench for the interrupt priority register block
// Assumes: APB master acting at the rising edge; bench owns every input
// Notes: A register model mirrors writes; read results are matched from a queue
`timescale 1ns/1ns
module ipr_regs_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [14:0] src = 15'h0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ipr_pkg::ipr_prio_t prio;
    logic [44:0] lv;
    logic [14:0] act;
    logic [15:0] m [4];
    logic [32:0] q [$];
    int n_errors = 0;
    int checks_done = 0;
    int seed = 32'hf2a1;
    int idx;
    ipr_regs uut (.sys_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .src_req_in(src), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .prio_out(prio), .level_out(lv), .req_active_out(act));
    // 10 MHz clock
    initial begin
        forever #50 clk = ~clk;
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize();
        $display("mismatches %0d of %0d checks", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Field order follows level_out: compare7 at the top, timer9 at the bottom
    function logic [44:0] exp_lv();
        return {m[0][14:12], m[0][10:8], m[0][6:4], m[0][2:0], m[1][14:12], m[1][10:8], m[1][2:0],
            m[2][14:12], m[2][10:8], m[2][6:4], m[2][2:0], m[3][14:12], m[3][10:8], m[3][6:4], m[3][2:0]};
    endfunction
    // One APB transfer; model updated for mapped words only, read note queued for every read
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        logic [15:0] wm;
        wm = ((a[3:2] == 2'h1) ? ipr_pkg::MASK_TDC : ipr_pkg::MASK_FULL) & {{8{s[1]}}, {8{s[0]}}};
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        if (!w) q.push_back((a[11:4] == 8'h00) ? {17'h0, m[a[3:2]]} : {1'b1, 32'h0});
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            summarize();
        end
        if (w && a[11:4] == 8'h00) m[a[3:2]] = (m[a[3:2]] & ~wm) | (d[15:0] & wm);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Outputs are judged mid-cycle, once the write edge has landed
    task chk_out();
        logic [44:0] e;
        logic [14:0] ea;
        @(negedge clk);
        e = exp_lv();
        for (int i = 0; i < 15; i++) ea[i] = src[i] && (e[3*i+:3] != ipr_pkg::PRIO_OFF);
        check(lv, e);
        check(prio, e);
        check(act, ea);
    endtask
    task reset_all();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        m = '{ipr_pkg::RST_FULL, ipr_pkg::RST_TDC, ipr_pkg::RST_FULL, ipr_pkg::RST_FULL};
        for (int i = 0; i < 5; i++) apb(1'b0, 12'(i * 4), 32'h0, 4'h0);
        chk_out();
    endtask
    // Read results come back in request order
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check({31'h0, pslverr, prdata}, (q.size() > 0) ? q.pop_front() : 33'h1ffffffff);
        end
    end
    initial begin
        reset_all();
        $display("test reset values done");
        src <= 15'h7fff;
        // Every code into every field, with stray ones in absent bits
        for (int c = 0; c < 8; c++) begin
            for (int i = 0; i < 5; i++) apb(1'b1, 12'(i * 4), {16'hffff, {4{1'b1, 3'(c)}}}, 4'hf);
            chk_out();
            for (int i = 0; i < 4; i++) apb(1'b0, 12'(i * 4), 32'h0, 4'h0);
        end
        $display("test codes done");
        repeat (40) begin
            @(posedge clk);
            src <= 15'($random(seed));
            idx = {$random(seed)} % 5;
            apb(1'b1, 12'(idx * 4), $random(seed), 4'($random(seed)));
            apb(1'b0, 12'(idx * 4), 32'h0, 4'h0);
            chk_out();
        end
        $display("test random traffic done");
        reset_all();
        $display("test second reset done");
        summarize();
    end
endmodule // ipr_regs_tb
